// ### rtl/dcao_pkg.sv
// Constants, types and register map of the dual channel agreement output block
package dcao_pkg;

  // Timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int NS_PER_MS       = 1000000;
  localparam int JUDGE_PERIOD_MS = 10;
  localparam int CLK_PER_MS      = NS_PER_MS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [4:0] OFS_CONFIG     = 5'h00;
  localparam logic [4:0] OFS_TERM_SEL   = 5'h04;
  localparam logic [4:0] OFS_TIMES      = 5'h08;
  localparam logic [4:0] OFS_STATUS     = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLEAR  = 5'h14;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18;

  // Setting codes
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_02 = 2'h2;

  // Terminal function codes
  localparam logic [6:0] FUNC_AGREE  = 7'h58;  // 088
  localparam logic [6:0] FUNC_FBK_A  = 7'h5E;  // 094
  localparam logic [6:0] FUNC_FBK_B  = 7'h5F;  // 095
  localparam logic [6:0] FUNC_MAX    = 7'h62;  // 098
  localparam logic [6:0] TERM_A_RST  = 7'h02;  // 002
  localparam logic [6:0] TERM_B_RST  = 7'h01;  // 001
  localparam logic [6:0] TERM_C_RST  = 7'h11;  // 017

  // Change time reset values in ms
  localparam logic [15:0] SHUTOFF_TIME_RST = 16'h0064;
  localparam logic [15:0] RELEASE_TIME_RST = 16'h0064;

  // Interrupt bit positions
  localparam int IRQ_SHUTOFF = 0;
  localparam int IRQ_PATH1   = 1;
  localparam int IRQ_PATH2   = 2;
  localparam int IRQ_CHANGE  = 3;
  localparam int IRQ_W       = 4;

  typedef enum logic [7:0] {
    ST_PERMIT          = 8'h01,
    ST_CHB_OPEN_WIN    = 8'h02,
    ST_CHA_OPEN_WIN    = 8'h04,
    ST_CHB_EXPIRED     = 8'h08,
    ST_CHA_EXPIRED     = 8'h10,
    ST_CHB_RELEASE_WIN = 8'h20,
    ST_CHA_RELEASE_WIN = 8'h40,
    ST_BOTH_OPEN       = 8'h80
  } dcao_state_t;

  typedef struct packed {
    logic [1:0] after_window_action_select;
    logic [1:0] within_window_output_select;
    logic [1:0] safe_torque_display_select;
  } dcao_cfg_t;

  typedef struct packed {
    logic [6:0] terminal_c_function_select;
    logic [6:0] terminal_b_function_select;
    logic [6:0] terminal_a_function_select;
  } dcao_term_sel_t;

endpackage

// ### rtl/dcao_tick.sv
// Enable pulse divider producing one pulse per DIV enabled cycles
`timescale 1ns/1ps
module dcao_tick #(
  parameter int DIV = 10
) (
  input  wire logic CLOCK,  // System clock
  input  wire logic NRST,   // Async reset, active low
  input  wire logic en,     // Count enable
  output logic      tick    // One-cycle pulse
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  // Wrap at DIV-1 and pulse on the wrap
  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (en) begin
      if (cnt == 32'(DIV - 1)) begin
        next_cnt  = 32'h0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cnt  <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// ### rtl/dcao_judge.sv
// Agreement judgement, sampled only at judgement instants
`timescale 1ns/1ps
module dcao_judge
  import dcao_pkg::*;
(
  input  wire logic        CLOCK,   // System clock
  input  wire logic        NRST,    // Async reset, active low
  input  wire logic        judge,   // Judgement instant pulse
  input  dcao_state_t      state,   // Safe-stop state
  input  dcao_cfg_t        cfg,     // Selection settings
  output logic             agree,   // Held agreement result
  output logic             changed  // Pulse when result changed
);

  logic next_agree;
  logic next_changed;

  // Table lookup of the agreement result for one state
  function automatic logic agree_of(dcao_state_t s, dcao_cfg_t c);
    logic r;
    r = 1'b0;
    case (s)
      ST_PERMIT: r = 1'b1;
      ST_CHB_OPEN_WIN, ST_CHA_OPEN_WIN,
      ST_CHB_RELEASE_WIN, ST_CHA_RELEASE_WIN:
        r = (c.within_window_output_select == SEL_01);
      ST_CHB_EXPIRED, ST_CHA_EXPIRED:
        r = (c.after_window_action_select == SEL_01);
      ST_BOTH_OPEN: begin
        // Display select 02 forces off; otherwise channels agree
        if (c.safe_torque_display_select == SEL_02) begin
          r = 1'b0;
        end else begin
          r = 1'b1;
        end
      end
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Only the judgement pulse may move the result
  always_comb begin
    next_agree   = agree;
    next_changed = 1'b0;
    if (judge) begin
      next_agree   = agree_of(state, cfg);
      next_changed = (agree_of(state, cfg) != agree);
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      agree   <= 1'b0;
      changed <= 1'b0;
    end else begin
      agree   <= next_agree;
      changed <= next_changed;
    end
  end

endmodule

// ### rtl/dcao_top.sv
// Dual channel agreement output block with safe-stop states and Avalon-MM registers
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module dcao_top
  import dcao_pkg::*;
#(
  parameter int CLK_PER_MS_P = CLK_PER_MS
) (
  input  wire logic        CLOCK,                   // 50 MHz clock
  input  wire logic        NRST,                    // Async reset, active low
  input  wire logic [4:0]  AVS_ADDRESS,             // Byte address
  input  wire logic        AVS_READ,                // Read request
  input  wire logic        AVS_WRITE,               // Write request
  input  wire logic [31:0] AVS_WRITEDATA,           // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE,          // Byte lanes
  output logic      [31:0] AVS_READDATA,            // Read data
  output logic             AVS_WAITREQUEST,         // Stall
  input  wire logic        SAFETY_INPUT_A,          // Channel A, high = enabled
  input  wire logic        SAFETY_INPUT_B,          // Channel B, high = enabled
  output logic             CHANNEL_AGREEMENT_OUTPUT,// Agreement result
  output logic             OUTPUT_TERMINAL_A,       // Terminal A
  output logic             OUTPUT_TERMINAL_B,       // Terminal B
  output logic             OUTPUT_TERMINAL_C,       // Terminal C
  output logic             EXTERNAL_STATUS_MONITOR, // Reference monitor
  output logic             SHUTOFF_ERROR_TRIP,      // Both-open trip
  output logic             PATH_ONE_ERROR_TRIP,     // Channel B mismatch trip
  output logic             PATH_TWO_ERROR_TRIP,     // Channel A mismatch trip
  output logic             IRQ                      // Level interrupt
);

  // Settings and interrupt state
  dcao_cfg_t        cfg,        next_cfg;
  dcao_term_sel_t   term_sel,   next_term_sel;
  logic [15:0]      shutoff_change_time, next_shutoff_change_time;
  logic [15:0]      release_change_time, next_release_change_time;
  logic [IRQ_W-1:0] irq_status, next_irq_status;
  logic [IRQ_W-1:0] irq_enable, next_irq_enable;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // Bus handshake
  logic        next_waitrequest;
  logic [31:0] next_readdata;
  logic        bus_req;
  logic        bus_done;
  logic        wr_cfg, wr_term, wr_times, wr_clear, wr_enable;

  // State machine
  dcao_state_t state, next_state;
  logic [15:0] timer, next_timer;
  logic        ms_tick;
  logic        judge_tick;
  logic        agree;
  logic        agree_changed;
  logic        enter_path1;
  logic        enter_path2;
  logic        shutoff_hit;

  // Output staging
  logic next_term_a, next_term_b, next_term_c, next_monitor, next_agree_out;

  // Millisecond and judgement enables from one clock
  dcao_tick #(.DIV(CLK_PER_MS_P)) u_ms_tick (
    .CLOCK (CLOCK),
    .NRST  (NRST),
    .en    (1'b1),
    .tick  (ms_tick)
  );

  dcao_tick #(.DIV(JUDGE_PERIOD_MS)) u_judge_tick (
    .CLOCK (CLOCK),
    .NRST  (NRST),
    .en    (ms_tick),
    .tick  (judge_tick)
  );

  dcao_judge u_judge (
    .CLOCK   (CLOCK),
    .NRST    (NRST),
    .judge   (judge_tick),
    .state   (state),
    .cfg     (cfg),
    .agree   (agree),
    .changed (agree_changed)
  );

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Terminal function decode, shared by the three terminals
  function automatic logic term_of(logic [6:0] sel, logic ag, logic a, logic b);
    logic r;
    r = 1'b0;
    if (sel == FUNC_AGREE) begin
      r = ag;
    end else if (sel == FUNC_FBK_A) begin
      r = a;
    end else if (sel == FUNC_FBK_B) begin
      r = b;
    end
    return r;
  endfunction

  // Completion happens on the edge that sees waitrequest low
  assign bus_req  = AVS_READ | AVS_WRITE;
  assign bus_done = bus_req & ~AVS_WAITREQUEST;
  assign wr_cfg    = AVS_WRITE & bus_done & (AVS_ADDRESS[4:2] == OFS_CONFIG[4:2]);
  assign wr_term   = AVS_WRITE & bus_done & (AVS_ADDRESS[4:2] == OFS_TERM_SEL[4:2]);
  assign wr_times  = AVS_WRITE & bus_done & (AVS_ADDRESS[4:2] == OFS_TIMES[4:2]);
  assign wr_clear  = AVS_WRITE & bus_done & (AVS_ADDRESS[4:2] == OFS_IRQ_CLEAR[4:2]);
  assign wr_enable = AVS_WRITE & bus_done & (AVS_ADDRESS[4:2] == OFS_IRQ_ENABLE[4:2]);

  // Bus answer: one wait cycle, read data latched with the release
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata    = AVS_READDATA;
    if (bus_req && AVS_WAITREQUEST) begin
      next_waitrequest = 1'b0;
      next_readdata    = 32'h0;
      if (AVS_ADDRESS[4:2] == OFS_CONFIG[4:2]) begin
        next_readdata = {26'h0, cfg};
      end else if (AVS_ADDRESS[4:2] == OFS_TERM_SEL[4:2]) begin
        next_readdata = {9'h0, term_sel.terminal_c_function_select, 1'b0,
                         term_sel.terminal_b_function_select, 1'b0,
                         term_sel.terminal_a_function_select};
      end else if (AVS_ADDRESS[4:2] == OFS_TIMES[4:2]) begin
        next_readdata = {release_change_time, shutoff_change_time};
      end else if (AVS_ADDRESS[4:2] == OFS_STATUS[4:2]) begin
        next_readdata = {16'h0, 3'h0, timer == 16'h0, SAFETY_INPUT_B, SAFETY_INPUT_A,
                         1'b0, agree, state};
      end else if (AVS_ADDRESS[4:2] == OFS_IRQ_STATUS[4:2]) begin
        next_readdata = {28'h0, irq_status};
      end else if (AVS_ADDRESS[4:2] == OFS_IRQ_ENABLE[4:2]) begin
        next_readdata = {28'h0, irq_enable};
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0;
    end else begin
      AVS_WAITREQUEST <= next_waitrequest;
      AVS_READDATA    <= next_readdata;
    end
  end

  // Register writes; out-of-range terminal codes leave the old code
  always_comb begin
    logic [31:0] w;
    w                        = 32'h0;
    next_cfg                 = cfg;
    next_term_sel            = term_sel;
    next_shutoff_change_time = shutoff_change_time;
    next_release_change_time = release_change_time;
    next_irq_enable          = irq_enable;
    if (wr_cfg) begin
      w        = merge({26'h0, cfg}, AVS_WRITEDATA, AVS_BYTEENABLE);
      next_cfg = w[5:0];
    end
    if (wr_term) begin
      if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[6:0] <= FUNC_MAX) begin
        next_term_sel.terminal_a_function_select = AVS_WRITEDATA[6:0];
      end
      if (AVS_BYTEENABLE[1] && AVS_WRITEDATA[14:8] <= FUNC_MAX) begin
        next_term_sel.terminal_b_function_select = AVS_WRITEDATA[14:8];
      end
      if (AVS_BYTEENABLE[2] && AVS_WRITEDATA[22:16] <= FUNC_MAX) begin
        next_term_sel.terminal_c_function_select = AVS_WRITEDATA[22:16];
      end
    end
    if (wr_times) begin
      w = merge({release_change_time, shutoff_change_time}, AVS_WRITEDATA, AVS_BYTEENABLE);
      next_shutoff_change_time = w[15:0];
      next_release_change_time = w[31:16];
    end
    if (wr_enable && AVS_BYTEENABLE[0]) begin
      next_irq_enable = AVS_WRITEDATA[IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cfg                 <= '0;
      term_sel            <= {TERM_C_RST, TERM_B_RST, TERM_A_RST};
      shutoff_change_time <= SHUTOFF_TIME_RST;
      release_change_time <= RELEASE_TIME_RST;
      irq_enable          <= '0;
    end else begin
      cfg                 <= next_cfg;
      term_sel            <= next_term_sel;
      shutoff_change_time <= next_shutoff_change_time;
      release_change_time <= next_release_change_time;
      irq_enable          <= next_irq_enable;
    end
  end

  // Safe-stop state walk; timer counts down change time in ms
  always_comb begin
    logic a, b;
    a          = SAFETY_INPUT_A;
    b          = SAFETY_INPUT_B;
    next_state = state;
    next_timer = (ms_tick && timer != 16'h0) ? timer - 16'h1 : timer;
    case (state)
      ST_PERMIT: begin
        if (!a && !b) begin
          next_state = ST_BOTH_OPEN;
        end else if (a && !b) begin
          next_state = ST_CHB_OPEN_WIN;
          next_timer = shutoff_change_time;
        end else if (!a && b) begin
          next_state = ST_CHA_OPEN_WIN;
          next_timer = shutoff_change_time;
        end
      end
      ST_CHB_OPEN_WIN, ST_CHA_OPEN_WIN: begin
        // Channel back on or window expired both mean mismatch
        if (!a && !b) begin
          next_state = ST_BOTH_OPEN;
        end else if ((a && b) || timer == 16'h0) begin
          next_state = (state == ST_CHB_OPEN_WIN) ? ST_CHB_EXPIRED : ST_CHA_EXPIRED;
        end
      end
      ST_CHB_RELEASE_WIN, ST_CHA_RELEASE_WIN: begin
        if (a && b) begin
          next_state = ST_PERMIT;
        end else if (!a && !b) begin
          next_state = ST_BOTH_OPEN;
        end else if (timer == 16'h0) begin
          next_state = (state == ST_CHB_RELEASE_WIN) ? ST_CHB_EXPIRED : ST_CHA_EXPIRED;
        end
      end
      ST_CHB_EXPIRED, ST_CHA_EXPIRED: begin
        // Mismatch clears only through both channels open
        if (!a && !b) begin
          next_state = ST_BOTH_OPEN;
        end
      end
      ST_BOTH_OPEN: begin
        if (a && b) begin
          next_state = ST_PERMIT;
        end else if (!a && b) begin
          next_state = ST_CHB_RELEASE_WIN;
          next_timer = release_change_time;
        end else if (a && !b) begin
          next_state = ST_CHA_RELEASE_WIN;
          next_timer = release_change_time;
        end
      end
      default: next_state = ST_BOTH_OPEN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_BOTH_OPEN;
      timer <= 16'h0;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Trip events
  assign enter_path1 = (cfg.after_window_action_select == SEL_02) &&
                       (next_state == ST_CHB_EXPIRED) && (state != ST_CHB_EXPIRED);
  assign enter_path2 = (cfg.after_window_action_select == SEL_02) &&
                       (next_state == ST_CHA_EXPIRED) && (state != ST_CHA_EXPIRED);
  assign shutoff_hit = (cfg.safe_torque_display_select == SEL_02) &&
                       (state == ST_BOTH_OPEN);
  assign irq_set = {agree_changed, enter_path2, enter_path1, shutoff_hit};
  assign irq_clr = (wr_clear && AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[IRQ_W-1:0] : '0;

  // Sticky status; a set in the clearing cycle wins
  always_comb begin
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Pin outputs, all registered
  always_comb begin
    next_agree_out = agree;
    next_term_a    = term_of(term_sel.terminal_a_function_select, agree,
                             SAFETY_INPUT_A, SAFETY_INPUT_B);
    next_term_b    = term_of(term_sel.terminal_b_function_select, agree,
                             SAFETY_INPUT_A, SAFETY_INPUT_B);
    next_term_c    = term_of(term_sel.terminal_c_function_select, agree,
                             SAFETY_INPUT_A, SAFETY_INPUT_B);
    // Reference only: both inputs open and no trip latched
    next_monitor   = !SAFETY_INPUT_A && !SAFETY_INPUT_B &&
                     (irq_status[IRQ_PATH2:IRQ_SHUTOFF] == 3'h0);
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      CHANNEL_AGREEMENT_OUTPUT <= 1'b0;
      OUTPUT_TERMINAL_A        <= 1'b0;
      OUTPUT_TERMINAL_B        <= 1'b0;
      OUTPUT_TERMINAL_C        <= 1'b0;
      EXTERNAL_STATUS_MONITOR  <= 1'b0;
      SHUTOFF_ERROR_TRIP       <= 1'b0;
      PATH_ONE_ERROR_TRIP      <= 1'b0;
      PATH_TWO_ERROR_TRIP      <= 1'b0;
      IRQ                      <= 1'b0;
    end else begin
      CHANNEL_AGREEMENT_OUTPUT <= next_agree_out;
      OUTPUT_TERMINAL_A        <= next_term_a;
      OUTPUT_TERMINAL_B        <= next_term_b;
      OUTPUT_TERMINAL_C        <= next_term_c;
      EXTERNAL_STATUS_MONITOR  <= next_monitor;
      SHUTOFF_ERROR_TRIP       <= next_irq_status[IRQ_SHUTOFF];
      PATH_ONE_ERROR_TRIP      <= next_irq_status[IRQ_PATH1];
      PATH_TWO_ERROR_TRIP      <= next_irq_status[IRQ_PATH2];
      IRQ                      <= |(next_irq_status & next_irq_enable);
    end
  end

endmodule

// ### sim/dcao_relay.sv
// Model of the external safety relay unit driving both channels
`timescale 1ns/1ps
module dcao_relay #(
  parameter int PULSE_CYC = 10
) (
  input  wire logic CLOCK,   // Clock
  input  wire logic want_a,  // Wanted channel A
  input  wire logic want_b,  // Wanted channel B
  input  wire logic pulse_b, // Start off-pulse on B
  output logic      out_a,   // Channel A contact
  output logic      out_b    // Channel B contact
);
  int left = 0;
  int next_left;
  // Off-pulse length; 10 cycles is 0.2 us, far inside the 500 us limit
  always_comb begin
    next_left = (left > 0) ? left - 1 : 0;
    if (pulse_b) begin
      next_left = PULSE_CYC;
    end
  end
  // Contacts move just after an edge; the status monitor is never read
  always_ff @(posedge CLOCK) begin
    left  <= next_left;
    out_a <= want_a;
    out_b <= want_b && (next_left == 0);
  end
endmodule

// ### sim/dcao_top_assertions.sv
// Port-level assertions for the agreement output block
`timescale 1ns/1ps
module dcao_top_assertions
  import dcao_pkg::*;
#(
  parameter int CLK_PER_MS_P = CLK_PER_MS
) (
  input wire logic       CLOCK,                    // Clock
  input wire logic       NRST,                     // Reset
  input wire logic [4:0] AVS_ADDRESS,              // Address
  input wire logic       AVS_READ,                 // Read
  input wire logic       AVS_WRITE,                // Write
  input wire logic       AVS_WAITREQUEST,          // Stall
  input wire logic       SAFETY_INPUT_A,           // Channel A
  input wire logic       SAFETY_INPUT_B,           // Channel B
  input wire logic       CHANNEL_AGREEMENT_OUTPUT, // Agreement
  input wire logic       EXTERNAL_STATUS_MONITOR,  // Monitor
  input wire logic       SHUTOFF_ERROR_TRIP,       // Trip
  input wire logic       PATH_ONE_ERROR_TRIP,      // Trip
  input wire logic       PATH_TWO_ERROR_TRIP       // Trip
);
  localparam int PERIOD = JUDGE_PERIOD_MS * CLK_PER_MS_P;
  logic agree_q, both_low, any_high, clr_wr, any_trip;
  int   since, next_since;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  // Causes that each flag may follow
  assign both_low = !SAFETY_INPUT_A && !SAFETY_INPUT_B;
  assign any_high = SAFETY_INPUT_A || SAFETY_INPUT_B;
  assign clr_wr   = AVS_WRITE && !AVS_WAITREQUEST && (AVS_ADDRESS == OFS_IRQ_CLEAR);
  assign any_trip = SHUTOFF_ERROR_TRIP || PATH_ONE_ERROR_TRIP || PATH_TWO_ERROR_TRIP;

  // Cycles since agreement moved; saturates to stay small
  always_comb begin
    next_since = (since < PERIOD) ? since + 1 : since;
    if (CHANNEL_AGREEMENT_OUTPUT != agree_q) begin
      next_since = 0;
    end
  end
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      since   <= 0;
      agree_q <= 1'b0;
    end else begin
      since   <= next_since;
      agree_q <= CHANNEL_AGREEMENT_OUTPUT;
    end
  end

  a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after a request");
  a_wait_back: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_agree_steady: assert property ($changed(CHANNEL_AGREEMENT_OUTPUT) |-> since >= PERIOD - 1)
    else $error("agreement moved between judgements");
  a_shutoff_cause: assert property ($rose(SHUTOFF_ERROR_TRIP) |->
    $past(both_low) || $past(both_low, 2) || $past(both_low, 3))
    else $error("shutoff trip without both channels open");
  a_path_one: assert property ($rose(PATH_ONE_ERROR_TRIP) |->
    $past(any_high) || $past(any_high, 2) || $past(any_high, 3))
    else $error("path one trip with both channels open");
  a_path_two: assert property ($rose(PATH_TWO_ERROR_TRIP) |->
    $past(any_high) || $past(any_high, 2) || $past(any_high, 3))
    else $error("path two trip with both channels open");
  a_monitor_cause: assert property (EXTERNAL_STATUS_MONITOR |->
    ($past(both_low) || $past(both_low, 2)))
    else $error("monitor high with a channel enabled");
  a_trip_sticky: assert property ($fell(any_trip) |-> $past(clr_wr) || $past(clr_wr, 2))
    else $error("trip dropped without a clear write");

  c_path: cover property ($rose(PATH_ONE_ERROR_TRIP));
  c_shutoff: cover property ($rose(SHUTOFF_ERROR_TRIP));
  c_agree: cover property ($changed(CHANNEL_AGREEMENT_OUTPUT));
endmodule

bind dcao_top dcao_top_assertions #(.CLK_PER_MS_P(CLK_PER_MS_P)) i_chk (
  .CLOCK(CLOCK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .SAFETY_INPUT_A(SAFETY_INPUT_A), .SAFETY_INPUT_B(SAFETY_INPUT_B),
  .CHANNEL_AGREEMENT_OUTPUT(CHANNEL_AGREEMENT_OUTPUT),
  .EXTERNAL_STATUS_MONITOR(EXTERNAL_STATUS_MONITOR), .SHUTOFF_ERROR_TRIP(SHUTOFF_ERROR_TRIP),
  .PATH_ONE_ERROR_TRIP(PATH_ONE_ERROR_TRIP), .PATH_TWO_ERROR_TRIP(PATH_TWO_ERROR_TRIP)
);

// ### sim/dcao_top_test.sv
// Self-checking bench for the agreement output block
`timescale 1ns/1ps
module dcao_top_test
  import dcao_pkg::*;
;
  localparam int MS     = 10;           // Shortened clocks per ms
  localparam int SETTLE = 20 * MS + 10; // Two judgement periods
  logic        CLOCK = 1'b0, NRST = 1'b0, rd = 1'b0, wr = 1'b0, pulse_b = 1'b0;
  logic        want_a = 1'b0, want_b = 1'b0, wq, sa, sb, agree, t_a, t_b, t_c;
  logic        mon, trip0, trip1, trip2, irq;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  int          bad_count = 0, comparisons = 0, n;

  // 50 MHz clock
  initial begin
    forever #10 CLOCK = ~CLOCK;
  end

  dcao_relay i_relay (
    .CLOCK(CLOCK), .want_a(want_a), .want_b(want_b), .pulse_b(pulse_b),
    .out_a(sa), .out_b(sb)
  );
  dcao_top #(.CLK_PER_MS_P(MS)) i_dut (
    .CLOCK(CLOCK), .NRST(NRST), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wq), .SAFETY_INPUT_A(sa), .SAFETY_INPUT_B(sb),
    .CHANNEL_AGREEMENT_OUTPUT(agree), .OUTPUT_TERMINAL_A(t_a), .OUTPUT_TERMINAL_B(t_b),
    .OUTPUT_TERMINAL_C(t_c), .EXTERNAL_STATUS_MONITOR(mon), .SHUTOFF_ERROR_TRIP(trip0),
    .PATH_ONE_ERROR_TRIP(trip1), .PATH_TWO_ERROR_TRIP(trip2), .IRQ(irq)
  );

  task automatic fail(input string msg);
    bad_count++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) fail("flag differs");
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("got %h want %h", got, exp));
  endtask
  // One transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLOCK);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    do begin
      @(posedge CLOCK);
      k++;
    end while (wq !== 1'b0 && k < 20);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 20) begin
      fail("bus hang");
      wrap_up();
    end
  endtask
  task automatic chk_reg(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp32(q & m, e);
  endtask
  // Relay levels, then a few edges for the state to follow
  task automatic set_in(input logic a, input logic b);
    @(posedge CLOCK);
    want_a <= a;
    want_b <= b;
    repeat (4) @(posedge CLOCK);
  endtask
  task automatic wait_agree(input logic v);
    n = 0;
    while (agree !== v && n < 300) begin
      @(posedge CLOCK);
      n++;
    end
    if (n >= 300) begin
      fail("agreement wait timed out");
      wrap_up();
    end
  endtask

  initial begin
    repeat (16) @(posedge CLOCK);
    NRST <= 1'b1;
    chk_reg(OFS_TERM_SEL, 32'hFFFF_FFFF, 32'h0011_0102);
    chk_reg(OFS_TIMES, 32'hFFFF_FFFF, 32'h0064_0064);
    chk_reg(5'h1C, 32'hFFFF_FFFF, 32'h0);
    cmp32({29'h0, t_a, t_b, t_c}, 32'h0);
    // Code above 098 is refused, the others land
    bus(1'b1, OFS_TERM_SEL, 32'h0063_5E58);
    chk_reg(OFS_TERM_SEL, 32'hFFFF_FFFF, 32'h0011_5E58);
    set_in(1'b1, 1'b1);
    chk_reg(OFS_STATUS, 32'hFF, 32'h01);
    repeat (SETTLE) @(posedge CLOCK);
    cmp32({29'h0, agree, t_a, t_b}, 32'h7);
    // Fall inside the window, rise exactly one judgement later
    bus(1'b1, OFS_CONFIG, 32'h10);
    set_in(1'b1, 1'b0);
    wait_agree(1'b0);
    cmp1(n < 110, 1'b1);
    want_b <= 1'b1;
    wait_agree(1'b1);
    cmp32(n, JUDGE_PERIOD_MS * MS);
    set_in(1'b0, 1'b0);
    for (int w = 0; w < 2; w++) begin
      for (int c = 0; c < 2; c++) begin
        bus(1'b1, OFS_CONFIG, w ? 32'h4 : 32'h0);
        set_in(1'b1, 1'b1);
        set_in(c[0], !c[0]);
        chk_reg(OFS_STATUS, 32'hFF, c ? 32'h02 : 32'h04);
        repeat (SETTLE) @(posedge CLOCK);
        cmp1(agree, w[0]);
        set_in(1'b0, 1'b0);
        set_in(!c[0], c[0]);
        chk_reg(OFS_STATUS, 32'hFF, c ? 32'h20 : 32'h40);
        repeat (SETTLE) @(posedge CLOCK);
        cmp1(agree, w[0]);
        set_in(1'b0, 1'b0);
      end
    end
    // Short shutoff window so that it expires
    bus(1'b1, OFS_TIMES, 32'h0064_0002);
    for (int a = 0; a < 3; a++) begin
      for (int c = 0; c < 2; c++) begin
        bus(1'b1, OFS_CONFIG, {26'h0, a[1:0], 4'h0});
        set_in(1'b1, 1'b1);
        set_in(c[0], !c[0]);
        repeat (SETTLE) @(posedge CLOCK);
        chk_reg(OFS_STATUS, 32'hFF, c ? 32'h08 : 32'h10);
        cmp1(agree, a == 1);
        cmp32({30'h0, trip2, trip1}, (a == 2) ? (c ? 32'h1 : 32'h2) : 32'h0);
        set_in(1'b0, 1'b0);
        bus(1'b1, OFS_IRQ_CLEAR, 32'hF);
      end
    end
    for (int d = 0; d < 3; d++) begin
      for (int a = 1; a < 3; a++) begin
        bus(1'b1, OFS_CONFIG, {26'h0, a[1:0], 2'h0, d[1:0]});
        repeat (SETTLE) @(posedge CLOCK);
        cmp32({29'h0, agree, trip0, mon}, (d == 2) ? 32'h2 : 32'h5);
        bus(1'b1, OFS_CONFIG, 32'h0);
        bus(1'b1, OFS_IRQ_CLEAR, 32'hF);
      end
    end
    // Interrupt raised, masked, then cleared
    bus(1'b1, OFS_IRQ_ENABLE, 32'h1);
    bus(1'b1, OFS_CONFIG, 32'h2);
    repeat (4) @(posedge CLOCK);
    cmp1(irq, 1'b1);
    chk_reg(OFS_IRQ_STATUS, 32'h7, 32'h1);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
    repeat (4) @(posedge CLOCK);
    cmp1(irq, 1'b0);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h1);
    bus(1'b1, OFS_CONFIG, 32'h0);
    bus(1'b1, OFS_IRQ_CLEAR, 32'hF);
    repeat (4) @(posedge CLOCK);
    cmp32({30'h0, irq, trip0}, 32'h0);
    chk_reg(OFS_IRQ_CLEAR, 32'hFFFF_FFFF, 32'h0);
    // Brief test off-pulse on B leaves a mismatch behind
    set_in(1'b1, 1'b1);
    pulse_b <= 1'b1;
    @(posedge CLOCK);
    pulse_b <= 1'b0;
    repeat (60) @(posedge CLOCK);
    chk_reg(OFS_STATUS, 32'hFF, 32'h08);
    wrap_up();
  end
endmodule
